// File: plc_pkg.sv
package plc_pkg;
   // Operating modes of the cell
   typedef enum logic [1:0] {
      PLC_MODE_NORMAL,
      PLC_MODE_ARITH,
      PLC_MODE_UPDOWN,
      PLC_MODE_CLRCNT
   } plc_mode_t;

   // Register behaviour
   typedef enum logic [1:0] {
      PLC_REG_D,
      PLC_REG_T,
      PLC_REG_JK,
      PLC_REG_SR
   } plc_reg_t;

   // Clear and preset arrangement
   typedef enum logic [2:0] {
      PLC_CP_CLEAR,
      PLC_CP_PRESET,
      PLC_CP_CLEAR_PRESET,
      PLC_CP_LOAD_CLEAR,
      PLC_CP_LOAD_PRESET,
      PLC_CP_LOAD_ONLY
   } plc_cp_t;

   localparam int         PLC_LUT_INPUTS   = 4;
   localparam int         PLC_LUT_SIZE     = 16;
   localparam int         PLC_HALF_SIZE    = 8;
   localparam int         PLC_CLUSTER_CELLS = 8;
   localparam int         PLC_CLUSTER_SKIP = 2;
   localparam logic       PLC_REG_RESET    = 1'b0;
   localparam logic [15:0] PLC_LUT_DEFAULT = 16'h0000;
   // Arithmetic defaults: sum = a^b^cin, carry = majority
   localparam logic [7:0] PLC_SUM_DEFAULT  = 8'h96;
   localparam logic [7:0] PLC_CARRY_DEFAULT = 8'he8;
endpackage

// File: plc_lut.sv
`timescale 1ns/1ps
// Generic table lookup, table bit chosen by the index
module plc_lut #(
   parameter int W = 4
) (
   input  wire logic [(1<<W)-1:0] table_bits,
   input  wire logic [W-1:0]      index,
   output      logic              result
);
   assign result = table_bits[index];
endmodule

// File: plc_logic_cell.sv
`timescale 1ns/1ps
// How it works
// - Four-input table gives any function
// - Register acts as D, T, JK, SR
// - Combinational use bypasses the register
// - Two outputs, each table or register
// - Carry input feeds table and carry logic
// - Long carry chains skip to alternate cluster
// - Carry chain breaks at memory block
// - Adder bit forms sum; extra cell carries
// - Sum is combinational or accumulated
// - Cascade ANDs table with cascade input
// - Each cascaded cell adds four inputs
// - Long cascade chains skip alternate cluster
// - Cascade chain breaks at row centre
// - Four modes: normal, arithmetic, two counters
// - Six logic inputs plus clock, clear, preset
// - Synchronous clock enable from first input
// - Packed register excludes cascade chain
// - Normal mode picks carry or third input
// - Normal mode table merges into cascade
// - Packed register fed by fourth input
// - Packed register keeps enable, clear, preset
// - Arithmetic: sum table plus carry table
// - Up/down counter: enable, direction, load
// - Clearable counter ANDs load with clear
// - Clear and preset are active low
// - Device reset overrides all register controls
module plc_logic_cell #(
   parameter plc_pkg::plc_mode_t MODE         = plc_pkg::PLC_MODE_NORMAL,
   parameter plc_pkg::plc_reg_t  REG_TYPE     = plc_pkg::PLC_REG_D,
   parameter plc_pkg::plc_cp_t   CP_MODE      = plc_pkg::PLC_CP_CLEAR,
   parameter logic [15:0]        LUT_BITS     = plc_pkg::PLC_LUT_DEFAULT,
   parameter logic [7:0]         SUM_BITS     = plc_pkg::PLC_SUM_DEFAULT,
   parameter logic [7:0]         CARRY_BITS   = plc_pkg::PLC_CARRY_DEFAULT,
   parameter logic               USE_CARRY_IN = 1'b0,
   parameter logic               PACKED       = 1'b0,
   parameter logic               USE_ENABLE   = 1'b0,
   parameter logic               USE_CASCADE  = 1'b0,
   parameter logic               CASCADE_INV  = 1'b0,
   parameter logic               LOCAL_REG    = 1'b0,
   parameter logic               GLOBAL_REG   = 1'b0,
   parameter logic               CHIP_RESET_EN = 1'b1
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic cell_input_a,
   input  wire logic cell_input_b,
   input  wire logic cell_input_c,
   input  wire logic cell_input_d,
   input  wire logic carry_in,
   input  wire logic cascade_in,
   input  wire logic ctrl_one_n,
   input  wire logic ctrl_two_n,
   output      logic local_out,
   output      logic global_out,
   output      logic carry_out,
   output      logic cascade_out,
   output      logic reg_q
);
   // *****************************************************
   // Configuration checks
   // *****************************************************
   // static setup
   if (PACKED && USE_CASCADE) begin : g_bad_cfg
      $error("Packed register cannot join a cascade chain");
   end
   // four modes only; enum covers exactly these

   // *****************************************************
   // Table logic
   // *****************************************************
   logic       third_sel;
   logic [3:0] lut_index;
   logic [2:0] arith_index;
   logic       lut4_out;
   logic       sum_out;
   logic       carry_lut;
   logic       table_out;
   logic       counter_en;
   logic       direction;

   assign third_sel = USE_CARRY_IN ? carry_in : cell_input_c;
   assign lut_index = {cell_input_d, third_sel, cell_input_b, cell_input_a};

   plc_lut #(.W(4)) u_lut4 (
      .table_bits (LUT_BITS),
      .index      (lut_index),
      .result     (lut4_out)
   );

   // Counter modes: a = enable, b = direction in up/down (clearable counts up), q fed back
   assign counter_en = USE_ENABLE ? 1'b1 : cell_input_a;
   assign direction  = (MODE == plc_pkg::PLC_MODE_UPDOWN) ? cell_input_b : 1'b1;

   always_comb begin
      case (MODE)
         plc_pkg::PLC_MODE_ARITH:
            arith_index = {carry_in, cell_input_b, cell_input_a};
         plc_pkg::PLC_MODE_UPDOWN,
         plc_pkg::PLC_MODE_CLRCNT:
            arith_index = {carry_in, reg_q, direction};
         default:
            arith_index = 3'h0;
      endcase
   end

   plc_lut #(.W(3)) u_sum (
      .table_bits (SUM_BITS),
      .index      (arith_index),
      .result     (sum_out)
   );
   plc_lut #(.W(3)) u_carry (
      .table_bits (CARRY_BITS),
      .index      (arith_index),
      .result     (carry_lut)
   );

   assign table_out = (MODE == plc_pkg::PLC_MODE_NORMAL) ? lut4_out : sum_out;

   // *****************************************************
   // Chains
   // *****************************************************
   // carry onward
   // chain routing is external, one hop per cell
   assign carry_out = (MODE == plc_pkg::PLC_MODE_NORMAL) ? carry_in : carry_lut;

   always_comb begin
      if (USE_CASCADE && !PACKED) begin
         if (CASCADE_INV)
            cascade_out = ~((~table_out) & cascade_in);
         else
            cascade_out = table_out & cascade_in;
      end else begin
         cascade_out = table_out;
      end
   end

   // *****************************************************
   // Register input
   // *****************************************************
   logic load_sel;
   logic next_d;
   logic clock_en;
   logic next_q;
   logic chain_value;

   assign chain_value = USE_CASCADE ? cascade_out : table_out;

   assign clock_en = USE_ENABLE ? cell_input_a : 1'b1;

   always_comb begin
      load_sel = 1'b0;
      case (MODE)
         plc_pkg::PLC_MODE_UPDOWN: begin
            load_sel = cell_input_c ? cell_input_d : (counter_en ? sum_out : reg_q);
            next_d   = load_sel;
         end
         plc_pkg::PLC_MODE_CLRCNT: begin
            load_sel = cell_input_c ? cell_input_d : (counter_en ? sum_out : reg_q);
            next_d   = load_sel & cascade_in;
         end
         default:
            next_d = PACKED ? cell_input_d : chain_value;
      endcase
   end

   always_comb begin
      case (REG_TYPE)
         plc_pkg::PLC_REG_T:  next_q = reg_q ^ next_d;
         plc_pkg::PLC_REG_JK: next_q = (cell_input_b & ~reg_q) | (~cell_input_c & reg_q);
         plc_pkg::PLC_REG_SR: next_q = cell_input_b | (~cell_input_c & reg_q);
         default:             next_q = next_d;
      endcase
   end

   // *****************************************************
   // Clear, preset and load
   // *****************************************************
   logic clr_n;
   logic pre_n;

   // active low controls, unused held high
   always_comb begin
      case (CP_MODE)
         plc_pkg::PLC_CP_CLEAR: begin
            clr_n = ctrl_one_n & ctrl_two_n;
            pre_n = 1'b1;
         end
         plc_pkg::PLC_CP_PRESET: begin
            clr_n = 1'b1;
            pre_n = ctrl_one_n;
         end
         plc_pkg::PLC_CP_CLEAR_PRESET: begin
            clr_n = ctrl_two_n;
            pre_n = ctrl_one_n;
         end
         plc_pkg::PLC_CP_LOAD_CLEAR: begin
            clr_n = ctrl_two_n & (ctrl_one_n | cell_input_c);
            pre_n = ctrl_one_n | ~cell_input_c;
         end
         plc_pkg::PLC_CP_LOAD_PRESET: begin
            clr_n = ctrl_one_n | cell_input_c;
            pre_n = ctrl_two_n & (ctrl_one_n | ~cell_input_c);
         end
         default: begin
            clr_n = ctrl_one_n | cell_input_c;
            pre_n = ctrl_one_n | ~cell_input_c;
         end
      endcase
   end

   logic dev_rst_n;
   assign dev_rst_n = CHIP_RESET_EN ? reset_n : 1'b1;

   // *****************************************************
   // Register
   // *****************************************************
   // device reset first
   always_ff @(posedge clk or negedge dev_rst_n or negedge clr_n or negedge pre_n) begin
      if (!dev_rst_n)
         reg_q <= plc_pkg::PLC_REG_RESET;
      else if (!clr_n)
         reg_q <= 1'b0;
      else if (!pre_n)
         reg_q <= 1'b1;
      else if (clock_en)
         reg_q <= next_q;
   end

   // *****************************************************
   // Outputs
   // *****************************************************
   // independent output selection
   assign local_out  = LOCAL_REG  ? reg_q : chain_value;
   assign global_out = GLOBAL_REG ? reg_q : chain_value;

   // *****************************************************
   // Assertions
   // *****************************************************
   a_hold_disabled: assert property (@(posedge clk) disable iff (!reset_n)
      (dev_rst_n && !clock_en && clr_n && pre_n ##1 clr_n && pre_n) |-> $stable(reg_q))
      else $error("register changed without enable");
   a_reg_load: assert property (@(posedge clk) disable iff (!reset_n)
      (dev_rst_n && clock_en && clr_n && pre_n ##1 clr_n && pre_n) |-> reg_q == $past(next_q))
      else $error("register missed update");
   a_cascade_and: assert property (@(posedge clk) disable iff (!reset_n)
      (USE_CASCADE && !CASCADE_INV && !PACKED && !cascade_in) |-> !cascade_out)
      else $error("cascade low input not propagated");
   a_out_bypass: assert property (@(posedge clk) disable iff (!reset_n)
      !LOCAL_REG |-> local_out == chain_value)
      else $error("local output not bypassed");
   a_carry_add: assert property (@(posedge clk) disable iff (!reset_n)
      (MODE == plc_pkg::PLC_MODE_ARITH && CARRY_BITS == plc_pkg::PLC_CARRY_DEFAULT)
      |-> carry_out == ((cell_input_a & cell_input_b) | (carry_in & (cell_input_a ^ cell_input_b))))
      else $error("carry output wrong");
   a_clear_async: assert property (@(posedge clk) disable iff (!reset_n)
      !clr_n |-> !reg_q)
      else $error("clear did not hold register low");
   a_sync_clear: assert property (@(posedge clk) disable iff (!reset_n)
      (MODE == plc_pkg::PLC_MODE_CLRCNT && REG_TYPE == plc_pkg::PLC_REG_D && clock_en && dev_rst_n
       && !cascade_in && clr_n && pre_n ##1 clr_n && pre_n) |-> !reg_q)
      else $error("sync clear ignored");
   a_normal_sel: assert property (@(posedge clk) disable iff (!reset_n)
      (MODE == plc_pkg::PLC_MODE_NORMAL) |-> lut4_out == LUT_BITS[lut_index])
      else $error("table lookup wrong");
endmodule

// File: plc_nbr_model.sv
`timescale 1ns/1ps
// ****************************************
// Lower-order neighbour cell
// ****************************************
module plc_nbr_model #(
   parameter bit SLOW = 1'b0
) (
   input  wire logic clk,
   input  wire logic op_x,
   input  wire logic op_y,
   input  wire logic op_c,
   input  wire logic casc_src,
   output      logic carry,
   output      logic cascade
);
   logic carry_now;
   logic carry_late;

   assign carry_now = (op_x & op_y) | (op_c & (op_x ^ op_y));

   // Slow answer lags one cycle
   always_ff @(posedge clk) begin
      carry_late <= carry_now;
   end

   assign carry = SLOW ? carry_late : carry_now;

   assign cascade = casc_src;
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [4:0] in;
      logic       sum;
      logic       cy;
   } plc_row_t;

   logic     clk      = 1'b0;
   logic     reset_n  = 1'b0;
   logic     a        = 1'b0;
   logic     b        = 1'b0;
   logic     c        = 1'b0;
   logic     d        = 1'b0;
   logic     lo_x     = 1'b0;
   logic     lo_y     = 1'b0;
   logic     lo_c     = 1'b0;
   logic     casc_src = 1'b1;
   logic     ctl_one_n = 1'b1;
   logic     ctl_two_n = 1'b1;
   logic     carry;
   logic     cascade;
   logic     local_out;
   logic     global_out;
   logic     carry_out;
   logic     reg_q;
   logic     cas_out;
   logic     prev;
   logic     ci;
   plc_row_t rows [32];
   int       n_fail = 0;
   int       checks_done = 0;

   always #2 clk = ~clk;

   plc_nbr_model nbr (.clk(clk), .op_x(lo_x), .op_y(lo_y), .op_c(lo_c),
                      .casc_src(casc_src), .carry(carry), .cascade(cascade));

   plc_logic_cell #(.MODE(plc_pkg::PLC_MODE_ARITH), .GLOBAL_REG(1'b1)) dut (
      .clk(clk), .reset_n(reset_n), .cell_input_a(a), .cell_input_b(b),
      .cell_input_c(c), .cell_input_d(d), .carry_in(carry), .cascade_in(casc_src),
      .ctrl_one_n(ctl_one_n), .ctrl_two_n(ctl_two_n), .local_out(local_out),
      .global_out(global_out), .carry_out(carry_out), .cascade_out(), .reg_q(reg_q));

   plc_logic_cell #(.LUT_BITS(16'h8000), .USE_CASCADE(1'b1)) dut_cas (
      .clk(clk), .reset_n(reset_n), .cell_input_a(a), .cell_input_b(b),
      .cell_input_c(c), .cell_input_d(d), .carry_in(lo_c), .cascade_in(cascade),
      .ctrl_one_n(1'b1), .ctrl_two_n(1'b1), .local_out(), .global_out(),
      .carry_out(), .cascade_out(cas_out), .reg_q());

   task automatic cmp(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************
   // Watchdog
   // ****************************************
   initial begin
      #(1000*4);
      n_fail++;
      tally_and_finish();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      for (int i = 0; i < 32; i++) begin
         rows[i].in = i[4:0];
         ci = (i[4] & i[3]) | (i[2] & (i[4] ^ i[3]));
         rows[i].sum = i[1] ^ i[0] ^ ci;
         rows[i].cy = (i[1] & i[0]) | (ci & (i[1] ^ i[0]));
      end
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      prev = 1'b0;
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         {lo_x, lo_y, lo_c, a, b} <= rows[i].in;
         @(negedge clk);
         cmp(local_out, rows[i].sum, "sum output");
         cmp(carry_out, rows[i].cy, "carry output");
         cmp(reg_q, prev, "accumulated sum");
         cmp(global_out, prev, "register on global");
         prev = rows[i].sum;
      end
      $display("adder rows done");
      @(posedge clk);
      {lo_x, lo_y, lo_c, a, b} <= 5'h01;
      @(posedge clk);
      reset_n <= 1'b0;
      @(negedge clk);
      cmp(reg_q, 1'b0, "reset over clock");
      @(posedge clk);
      reset_n <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         repeat (2) @(posedge clk);
         if (k == 0) ctl_two_n <= 1'b0;
         else ctl_one_n <= 1'b0;
         repeat (2) @(negedge clk);
         cmp(reg_q, 1'b0, "clear held low");
         @(posedge clk);
         ctl_one_n <= 1'b1;
         ctl_two_n <= 1'b1;
         repeat (2) @(negedge clk);
         cmp(reg_q, 1'b1, "register after clear");
      end
      $display("reset and clear done");
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         {casc_src, d, c, b, a} <= i[4:0];
         @(negedge clk);
         cmp(cas_out, i[4] & (&i[3:0]), "cascade and");
      end
      $display("cascade rows done");
      tally_and_finish();
   end
endmodule
